/* File: hdl/cbar_arbiter.sv */
`timescale 1ns/1ps
// Behaviour
// - bus changes hands only after one idle clock; arbitration overlaps transfers.
// - state machine is synchronous, moving only on rising clock edge.
// - bus_request is asserted while an internal access is pending.
// - bus_request may drop at any clock regardless of grant or busy.
// - with grant already held, bus_request rises with transfer_start.
// - bus_request is always actively driven, never wired-OR.
// - grant removed mid-cycle: finish the cycle, then release the bus.
// - four-beat burst-inhibited line is one cycle; no release before fourth beat unless an error ack ends it.
// - atomic_last_write is asserted during the last write of a locked sequence.
// - after grant, wait for busy released, then assert busy and start.
// - busy held while granted once a cycle has started, not in implicit ownership; after grant loss, negate at cycle end, then float.
// - bus_request negates once no accesses remain pending.
// - implicit ownership drives undefined bus values, busy floated, no cycle.
// - implicit to active asserts busy, request, in-progress and start together.
// - grant still held after a cycle: park with busy asserted, undefined bus.
// - park to active raises request, in-progress, start; back to park drops in-progress; request just follows pending.
// - five states: idle, snoop, implicit ownership, park, active bus cycle.
// - idle neither owns nor drives the bus, except on its first clock after a release; busy reads negated.
// - snoop equals idle on the pins, but stands ready to serve snoops.
// - external bus_request is the internal request delayed by one register.
module cbar_arbiter
   import cbar_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rstn,
   input  wire cbar_acc_t  acc_i,
   input  wire logic       snoop_select,
   input  wire logic       bus_grant,
   input  wire logic       bus_busy_i,
   input  wire logic       transfer_ack,
   input  wire logic       transfer_error_ack,
   output logic            bus_request_q,
   output logic            bus_busy_o_q,
   output logic            bus_busy_oe_n_q,
   output logic            bus_oe_n_q,
   output logic            bus_defined_q,
   output logic            transfer_start_q,
   output logic            transfer_in_progress_q,
   output logic            atomic_sequence_flag_q,
   output logic            atomic_last_write_q,
   output logic            acc_taken_q,
   output logic            cycle_done_q,
   output logic            snoop_ready_q,
   output cbar_state_t     state_q
);

   cbar_state_t            state_d;
   logic                   release_q;
   logic                   releasing;
   logic                   start;
   logic                   cyc_last;
   logic                   line_q;
   logic                   locked_q;
   logic                   lock_last_q;
   logic [CBAR_BEAT_W-1:0] beat_cnt;
   logic                   owned_d;
   logic                   may_take;

   ////////////////////////////////////////////////////////////////////////////
   // beat tracking

   cbar_beat_cnt #(
      .BEATS  (CBAR_LINE_BEATS)
   ) u_beats (
      .clock  (clock),
      .rstn   (rstn),
      .start  (start),
      .active (state_q == CBAR_ACTIVE),
      .line   (line_q),
      .ack    (transfer_ack),
      .err    (transfer_error_ack),
      .last   (cyc_last),
      .cnt    (beat_cnt)
   );

   ////////////////////////////////////////////////////////////////////////////
   // arbitration state

   // busy seen negated while granted is the single idle clock between owners
   // our own release cycle drives busy low, so it must not count as free
   always_comb begin
      may_take = bus_grant && !bus_busy_i && !release_q;
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         CBAR_IDLE: begin
            if (may_take) begin
               state_d = acc_i.pending ? CBAR_ACTIVE : CBAR_IMPLICIT;
            end else if (snoop_select) begin
               state_d = CBAR_SNOOP;
            end
         end
         CBAR_SNOOP: begin
            if (may_take) begin
               state_d = acc_i.pending ? CBAR_ACTIVE : CBAR_IMPLICIT;
            end else if (!snoop_select) begin
               state_d = CBAR_IDLE;
            end
         end
         CBAR_IMPLICIT: begin
            if (!bus_grant) begin
               state_d = CBAR_IDLE;
            end else if (acc_i.pending) begin
               state_d = CBAR_ACTIVE;
            end
         end
         CBAR_PARK: begin
            if (!bus_grant) begin
               state_d = CBAR_IDLE;
            end else if (acc_i.pending) begin
               state_d = CBAR_ACTIVE;
            end
         end
         CBAR_ACTIVE: begin
            // grant is only looked at on the final acknowledge edge
            if (cyc_last) begin
               state_d = bus_grant ? CBAR_PARK : CBAR_IDLE;
            end
         end
         default: begin
            state_d = CBAR_IDLE;
         end
      endcase
   end

   always_comb begin
      start     = (state_d == CBAR_ACTIVE) && (state_q != CBAR_ACTIVE);
      releasing = (state_q == CBAR_PARK || state_q == CBAR_ACTIVE) && (state_d == CBAR_IDLE);
      owned_d   = (state_d == CBAR_PARK) || (state_d == CBAR_ACTIVE);
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_q   <= CBAR_IDLE;
         release_q <= 1'b0;
      end else begin
         state_q   <= state_d;
         release_q <= releasing;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // request pin

   // pure register delay: may fall at any clock, no look at grant or busy
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         bus_request_q <= CBAR_RST_REQUEST;
      end else begin
         bus_request_q <= acc_i.pending;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // busy and bus drive

   // busy is driven low for one clock before floating to speed the pullup
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         bus_busy_o_q    <= CBAR_RST_BUSY;
         bus_busy_oe_n_q <= CBAR_RST_OE_N;
      end else begin
         bus_busy_o_q    <= owned_d;
         bus_busy_oe_n_q <= !(owned_d || releasing);
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         bus_oe_n_q    <= CBAR_RST_OE_N;
         bus_defined_q <= 1'b0;
      end else begin
         bus_oe_n_q    <= !(owned_d || releasing || state_d == CBAR_IMPLICIT);
         bus_defined_q <= (state_d == CBAR_ACTIVE);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transfer control

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         transfer_start_q       <= 1'b0;
         transfer_in_progress_q <= 1'b0;
         acc_taken_q            <= 1'b0;
         cycle_done_q           <= 1'b0;
      end else begin
         transfer_start_q       <= start;
         transfer_in_progress_q <= (state_d == CBAR_ACTIVE);
         acc_taken_q            <= start;
         cycle_done_q           <= cyc_last;
      end
   end

   // access attributes held for the whole cycle
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         line_q      <= 1'b0;
         locked_q    <= 1'b0;
         lock_last_q <= 1'b0;
      end else if (start) begin
         line_q      <= acc_i.line;
         locked_q    <= acc_i.locked;
         lock_last_q <= acc_i.locked && acc_i.lock_last;
      end
   end

   // arbiter may watch the atomic flag to keep grant during a sequence
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         atomic_sequence_flag_q <= 1'b0;
         atomic_last_write_q    <= 1'b0;
      end else begin
         atomic_sequence_flag_q <= (state_d == CBAR_ACTIVE) &&
                                   (start ? acc_i.locked : locked_q);
         atomic_last_write_q    <= (state_d == CBAR_ACTIVE) &&
                                   (start ? (acc_i.locked && acc_i.lock_last) : lock_last_q);
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         snoop_ready_q <= 1'b0;
      end else begin
         snoop_ready_q <= (state_d == CBAR_SNOOP);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   a_req_delay_one: assert property (
      ##1 (bus_request_q == $past(acc_i.pending))
   ) else $error("bus_request does not follow the pending request by one clock");

   a_start_with_req: assert property (
      transfer_start_q |-> bus_request_q && transfer_in_progress_q && bus_busy_o_q && !bus_busy_oe_n_q
   ) else $error("transfer start without request, in-progress and busy");

   a_take_needs_free: assert property (
      (state_q == CBAR_IDLE) && (state_d != CBAR_IDLE) && (state_d != CBAR_SNOOP)
      |-> bus_grant && !bus_busy_i && !release_q
   ) else $error("bus taken while busy or ungranted");

   a_implicit_float: assert property (
      (state_q == CBAR_IMPLICIT) |-> bus_busy_oe_n_q && !bus_oe_n_q && !bus_defined_q && !transfer_in_progress_q
   ) else $error("implicit ownership drives busy or runs a cycle");

   a_implicit_go: assert property (
      (state_q == CBAR_IMPLICIT) && bus_grant && acc_i.pending
      |=> transfer_start_q && bus_request_q && transfer_in_progress_q && !bus_busy_oe_n_q
   ) else $error("implicit ownership did not start at once");

   a_park_hold: assert property (
      (state_q == CBAR_ACTIVE) && cyc_last && bus_grant |=> (state_q == CBAR_PARK) && bus_busy_o_q
      && !bus_busy_oe_n_q && !bus_defined_q && !transfer_in_progress_q
   ) else $error("no park after cycle with grant held");

   a_cycle_finish: assert property (
      (state_q == CBAR_ACTIVE) && !cyc_last && !bus_grant |=> (state_q == CBAR_ACTIVE) && bus_busy_o_q
   ) else $error("bus released before the cycle completed");

   a_release_order: assert property (
      (state_q == CBAR_ACTIVE) && cyc_last && !bus_grant
      |=> (!bus_busy_o_q && !bus_busy_oe_n_q) ##1 bus_busy_oe_n_q
   ) else $error("busy not negated then floated on release");

   a_line_four: assert property (
      (state_q == CBAR_ACTIVE) && line_q && transfer_ack && !transfer_error_ack && (beat_cnt != 2'h3)
      |=> (state_q == CBAR_ACTIVE)
   ) else $error("line cycle ended before its fourth beat");

   a_idle_float: assert property (
      (state_q == CBAR_IDLE) && !release_q |-> bus_busy_oe_n_q && bus_oe_n_q && !snoop_ready_q
   ) else $error("idle state drives the bus");

   a_lock_last: assert property (
      start && acc_i.locked && acc_i.lock_last |=> atomic_last_write_q throughout (state_q == CBAR_ACTIVE)[*1]
   ) else $error("last locked write not flagged");

   a_reset_idle: assert property (
      $rose(rstn) |-> (state_q == CBAR_IDLE) && !bus_request_q && bus_busy_oe_n_q
   ) else $error("not idle after reset");

   a_active_drive: assert property (
      (state_q == CBAR_ACTIVE) |-> bus_busy_o_q && !bus_busy_oe_n_q && !bus_oe_n_q
      && bus_defined_q && transfer_in_progress_q
   ) else $error("active cycle without busy, drive or in-progress");

   a_park_pins: assert property (
      (state_q == CBAR_PARK) |-> bus_busy_o_q && !bus_busy_oe_n_q && !bus_oe_n_q
      && !transfer_start_q && !transfer_in_progress_q
   ) else $error("park state pins wrong");

   a_snoop_pins: assert property (
      (state_q == CBAR_SNOOP) |-> bus_busy_oe_n_q && bus_oe_n_q && snoop_ready_q
   ) else $error("snoop state drives the bus or is not ready");

   a_idle_gap: assert property (
      release_q |=> (state_q == CBAR_IDLE) || (state_q == CBAR_SNOOP)
   ) else $error("bus taken again without an idle clock");

   a_start_pulse: assert property (
      transfer_start_q |=> !transfer_start_q
   ) else $error("transfer start longer than one clock");

   a_atomic_in_cycle: assert property (
      !transfer_in_progress_q |-> !atomic_last_write_q && !atomic_sequence_flag_q
   ) else $error("atomic flags outside a bus cycle");

   a_grant_lost_idle: assert property (
      ((state_q == CBAR_IMPLICIT) || (state_q == CBAR_PARK)) && !bus_grant |=> (state_q == CBAR_IDLE)
   ) else $error("ownership kept after grant removal");

   c_implicit_to_active: cover property (
      (state_q == CBAR_IMPLICIT) ##1 (state_q == CBAR_ACTIVE)
   );

   c_park_to_active: cover property (
      (state_q == CBAR_PARK) ##1 (state_q == CBAR_ACTIVE)
   );

   c_line_release: cover property (
      (state_q == CBAR_ACTIVE) && line_q && cyc_last && !bus_grant ##1 release_q
   );

   c_snoop_seen: cover property (
      (state_q == CBAR_SNOOP)
   );

   c_locked_last: cover property (
      atomic_last_write_q && transfer_in_progress_q
   );

endmodule

/* File: hdl/cbar_beat_cnt.sv */
`timescale 1ns/1ps
module cbar_beat_cnt
   import cbar_pkg::*;
#(
   parameter int BEATS = CBAR_LINE_BEATS
) (
   input  wire logic                     clock,
   input  wire logic                     rstn,
   input  wire logic                     start,
   input  wire logic                     active,
   input  wire logic                     line,
   input  wire logic                     ack,
   input  wire logic                     err,
   output logic                          last,
   output logic [$clog2(BEATS)-1:0]      cnt
);

   localparam int W = $clog2(BEATS);

   logic [W-1:0] cnt_q;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= '0;
      end else if (start) begin
         cnt_q <= '0;
      end else if (active && ack) begin
         cnt_q <= cnt_q + W'(1);
      end
   end

   // error ends the whole cycle, even a line mid-way
   always_comb begin
      last = active && (err || (ack && (!line || cnt_q == W'(BEATS - 1))));
      cnt  = cnt_q;
   end

endmodule

/* File: hdl/cbar_pkg.sv */
package cbar_pkg;

   // beats in one burst-inhibited line transfer, counted as one bus cycle
   localparam int   CBAR_LINE_BEATS   = 4;
   localparam int   CBAR_BEAT_W       = $clog2(CBAR_LINE_BEATS);

   // reset levels of the pins
   localparam logic CBAR_RST_REQUEST  = 1'b0;
   localparam logic CBAR_RST_BUSY     = 1'b0;
   localparam logic CBAR_RST_OE_N     = 1'b1;

   typedef enum logic [2:0] {
      CBAR_IDLE,
      CBAR_SNOOP,
      CBAR_IMPLICIT,
      CBAR_PARK,
      CBAR_ACTIVE
   } cbar_state_t;

   // internal access request from the memory units
   typedef struct packed {
      logic pending;
      logic line;
      logic locked;
      logic lock_last;
   } cbar_acc_t;

endpackage

/* File: verification/cbar_arbiter_tb_top.sv */
`timescale 1ns/1ps
module cbar_arbiter_tb_top
   import cbar_pkg::*;
;
   logic        clock = 1'b0;
   logic        rstn = 1'b0;
   cbar_acc_t   acc_i, acc_q;
   logic        snoop_select, hold_grant, am_req, err_req, am_mid;
   logic [1:0]  ack_wait;
   logic        bus_grant, busy_wire, transfer_ack, transfer_error_ack;
   logic        bus_request_q, bus_busy_o_q, bus_busy_oe_n_q, bus_oe_n_q, bus_defined_q;
   logic        transfer_start_q, transfer_in_progress_q, atomic_sequence_flag_q;
   logic        atomic_last_write_q, acc_taken_q, cycle_done_q, snoop_ready_q;
   cbar_state_t state_q;
   logic [7:0]  pins;
   logic        pend_s, gnt_s, line_s;
   logic        fin_s = 1'b0;
   logic        rel_s = 1'b0;
   int          error_cnt, total_checks, cyc, beats;
   integer      seed = 32'h462B7ED7;
   integer      r;

   always #12.5 clock = ~clock;
   assign pins = {1'b0, bus_busy_o_q, bus_busy_oe_n_q, bus_oe_n_q, bus_defined_q,
                  transfer_in_progress_q, transfer_start_q, acc_taken_q};

   cbar_arbiter u_cbar_arbiter (.clock, .rstn, .acc_i, .snoop_select, .bus_grant,
      .bus_busy_i(busy_wire), .transfer_ack, .transfer_error_ack, .bus_request_q, .bus_busy_o_q,
      .bus_busy_oe_n_q, .bus_oe_n_q, .bus_defined_q, .transfer_start_q, .transfer_in_progress_q,
      .atomic_sequence_flag_q, .atomic_last_write_q, .acc_taken_q, .cycle_done_q, .snoop_ready_q,
      .state_q);
   cbar_far_model u_cbar_far_model (.clock, .rstn, .bus_request(bus_request_q), .busy_o(bus_busy_o_q),
      .busy_oe_n(bus_busy_oe_n_q), .transfer_in_progress(transfer_in_progress_q), .atomic(atomic_sequence_flag_q),
      .hold_grant, .am_req, .ack_wait, .err_req, .bus_grant, .busy_wire, .transfer_ack,
      .transfer_error_ack);

   ////////////////////////////////////////////////////////////////////////////////
   // pin pattern per state; rel marks the one-cycle driven-low release
   function automatic logic [7:0] exp_pins(input cbar_state_t st, input logic rel);
      case (st)
         CBAR_ACTIVE:   return 8'h4F;
         CBAR_PARK:     return 8'h40;
         CBAR_IMPLICIT: return 8'h20;
         default:       return rel ? 8'h00 : 8'h30;
      endcase
   endfunction

   task automatic chk_vec(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_state(input string what, input cbar_state_t exp, input cbar_state_t got);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // hold the access until taken; pending drops on the cycle taken is seen
   task automatic do_access(input cbar_acc_t a);
      int n;
      acc_i = a;
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (acc_taken_q !== 1'b1 && n < 300);
      if (n >= 300) error_cnt++;
      acc_i = '0;
      am_req = am_mid;
      while (am_mid && cycle_done_q !== 1'b1 && n < 600) begin
         @(negedge clock);
         n++;
      end
      @(negedge clock);
      am_req = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clock) begin
      pend_s <= acc_i.pending;
      acc_q  <= acc_i;
   end

   always @(negedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         test_done();
      end else if (rstn) begin
         chk_vec("bus_request", {7'h00, pend_s}, {7'h00, bus_request_q});
         chk_vec("cycle_done", {7'h00, fin_s}, {7'h00, cycle_done_q});
         if (rel_s) chk_vec("float pins", exp_pins(CBAR_IDLE, 1'b0), pins);
         rel_s = 1'b0;
         if (cycle_done_q && gnt_s) begin
            chk_state("park state", CBAR_PARK, state_q);
            chk_vec("park pins", exp_pins(CBAR_PARK, 1'b0), pins);
         end else if (cycle_done_q) begin
            chk_vec("release pins", exp_pins(CBAR_IDLE, 1'b1), pins);
            rel_s = 1'b1;
         end
         fin_s = 1'b0;
         if (transfer_start_q) begin
            chk_vec("start pins", exp_pins(CBAR_ACTIVE, 1'b0), pins);
            chk_vec("start request", 8'h01, {7'h00, bus_request_q});
            chk_vec("atomic", {6'h00, acc_q.locked, acc_q.lock_last},
                    {6'h00, atomic_sequence_flag_q, atomic_last_write_q});
            beats = 0;
            line_s = acc_q.line;
         end
         if (transfer_in_progress_q && (transfer_ack || transfer_error_ack)) begin
            beats++;
            fin_s = transfer_error_ack || !line_s || beats == CBAR_LINE_BEATS;
            gnt_s = bus_grant;
         end
      end
   end

   initial begin
      acc_i = '0;
      snoop_select = 1'b0;
      hold_grant = 1'b0;
      am_req = 1'b0;
      err_req = 1'b0;
      am_mid = 1'b0;
      ack_wait = 2'h0;
      repeat (16) @(negedge clock);
      rstn = 1'b1;
      @(negedge clock);
      chk_vec("reset pins", exp_pins(CBAR_IDLE, 1'b0), pins);
      chk_state("reset state", CBAR_IDLE, state_q);
      snoop_select = 1'b1;
      repeat (3) @(negedge clock);
      chk_state("snoop state", CBAR_SNOOP, state_q);
      chk_vec("snoop pins", exp_pins(CBAR_SNOOP, 1'b0), pins);
      chk_vec("snoop ready", 8'h01, {7'h00, snoop_ready_q});
      snoop_select = 1'b0;
      am_req = 1'b1;
      repeat (4) @(negedge clock);
      // withdrawn request, bus never granted
      acc_i = 4'h8;
      @(negedge clock);
      acc_i = '0;
      repeat (4) @(negedge clock);
      am_req = 1'b0;
      hold_grant = 1'b1;
      repeat (6) @(negedge clock);
      chk_state("implicit state", CBAR_IMPLICIT, state_q);
      chk_vec("implicit pins", exp_pins(CBAR_IMPLICIT, 1'b0), pins);
      do_access(4'hC);
      for (int i = 0; i < 80; i++) begin
         r = $random(seed);
         ack_wait   = r[1:0];
         hold_grant = r[2];
         err_req    = (r[5:3] == 3'h0);
         am_mid     = (r[7:6] == 2'h0);
         if (r[8]) repeat (r[10:9]) @(negedge clock);
         do_access(cbar_acc_t'({1'b1, r[11], r[12], r[12] & r[13]}));
      end
      repeat (20) @(negedge clock);
      test_done();
   end
endmodule

/* File: verification/cbar_far_model.sv */
`timescale 1ns/1ps
// far side: external arbiter, one alternate master and an acking slave
module cbar_far_model
   import cbar_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rstn,
   input  wire logic       bus_request,
   input  wire logic       busy_o,
   input  wire logic       busy_oe_n,
   input  wire logic       transfer_in_progress,
   input  wire logic       atomic,
   input  wire logic       hold_grant,
   input  wire logic       am_req,
   input  wire logic [1:0] ack_wait,
   input  wire logic       err_req,
   output logic            bus_grant,
   output logic            busy_wire,
   output logic            transfer_ack,
   output logic            transfer_error_ack
);
   logic       am_gnt_q;
   logic       am_drv_q;
   logic [1:0] wait_q;
   logic       beat;
   // pull-up: busy reads negated once every party floats it
   assign busy_wire = (!busy_oe_n && busy_o) || am_drv_q;
   assign beat = transfer_in_progress && !transfer_ack && !transfer_error_ack && wait_q == ack_wait;
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         bus_grant          <= 1'b0;
         am_gnt_q           <= 1'b0;
         am_drv_q           <= 1'b0;
         wait_q             <= 2'h0;
         transfer_ack       <= 1'b0;
         transfer_error_ack <= 1'b0;
      end else begin
         // each grant waits for the other's to be low: one dead edge per hand-over
         bus_grant <= (!am_req || atomic) && (bus_request || hold_grant || atomic) && !am_gnt_q;
         am_gnt_q  <= am_req && !bus_grant;
         am_drv_q  <= am_gnt_q && (am_drv_q || !busy_wire);
         wait_q    <= (transfer_in_progress && !beat && wait_q != ack_wait) ? wait_q + 2'h1 : 2'h0;
         transfer_ack       <= beat && !err_req;
         transfer_error_ack <= beat && err_req;
      end
   end
endmodule
